// [inc/rdtl_consts.svh]
`ifndef RDTL_CONSTS_SVH
`define RDTL_CONSTS_SVH

// ==========================================================
// Register offsets
`define RDTL_OFF_CTRL 8'h00
`define RDTL_OFF_INSEL 8'h04
`define RDTL_OFF_NCPOL 8'h08
`define RDTL_OFF_OUTSEL 8'h0c
`define RDTL_OFF_STATUS 8'h10

// ==========================================================
// Reset values and writable masks
`define RDTL_RST_CTRL 32'h00000001
`define RDTL_RST_INSEL 32'h040c2040
`define RDTL_RST_NCPOL 32'h00000000
`define RDTL_RST_OUTSEL 32'h00000010
`define RDTL_MASK_CTRL 32'h0000000f
`define RDTL_MASK_INSEL 32'h3fffffff
`define RDTL_MASK_NCPOL 32'h0000001f
`define RDTL_MASK_OUTSEL 32'h000000ff

// ==========================================================
// Field positions
`define RDTL_CTRL_SRC 0
`define RDTL_CTRL_ROUTE 2
`define RDTL_CTRL_KPRUN 3
`define RDTL_INSEL_W 6
`define RDTL_OUTSEL_W 4
`define RDTL_ST_RUN 0
`define RDTL_ST_REV 1
`define RDTL_ST_FWDACT 2
`define RDTL_ST_REVACT 3
`define RDTL_ST_TERM 4
`define RDTL_ST_OUT 9

// ==========================================================
// Function codes
`define RDTL_SRC_TERMINAL 2'h1
`define RDTL_FN_FWD 6'h00
`define RDTL_FN_REV 6'h01
`define RDTL_OUT_MAX 4'h9

`endif

// [inc/rdtl_pkg.sv]
package rdtl_pkg;

   // ==========================================================
   // Wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } rdtl_wb_req_t;

   // ==========================================================
   // Drive command
   typedef struct packed {
      logic run;
      logic rev;
   } rdtl_drive_t;

   typedef enum logic [1:0] {
      RDTL_STOP = 2'b00,
      RDTL_RUN_FWD = 2'b01,
      RDTL_RUN_REV = 2'b10
   } rdtl_mode_t;

endpackage

// [rtl/rdtl_run_dir_top.sv]
// Functional notes
// - Forward-assigned input active runs forward; inactive means stop
// - Reverse-assigned input active runs reverse; inactive means stop
// - Forward and reverse both active gives stop
// - Normally-closed terminal inverts polarity; open terminal starts motor
// - Forward and reverse assignable through any of five selectors
// - Five input terminals identical, each programmable to any function
// - Keypad route picks keypad run direction only, not terminal commands
// - Command already active at power-up starts the motor
// - Output terminals select function by code 00 to 09
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rdtl_consts.svh"

module rdtl_run_dir_top #(
   parameter int NUM_IN = 5,
   parameter int NUM_OUT = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire rdtl_pkg::rdtl_wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Terminals and drive flags
   input wire logic [NUM_IN-1:0] term_pin_i,
   input wire logic [9:1] status_flags_i,
   // Drive command and output terminals
   output rdtl_pkg::rdtl_drive_t drive_o,
   output logic [NUM_OUT-1:0] out_term_o
);
   import rdtl_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [5:0] in_func(input logic [31:0] r, input int i);
      return r[i*`RDTL_INSEL_W +: `RDTL_INSEL_W];
   endfunction

   function automatic logic out_pick(input logic [3:0] code,
                                     input logic [9:0] flags);
      logic r;
      r = 1'b0;
      if (code <= `RDTL_OUT_MAX) begin
         r = flags[code];
      end
      return r;
   endfunction

   // ==========================================================
   // Terminal synchroniser
   logic [NUM_IN-1:0] term_s;

   rdtl_sync #(.WIDTH(NUM_IN)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(term_pin_i),
      .q_o(term_s)
   );

   // ==========================================================
   // Register file
   logic [31:0] ctrl;
   logic [31:0] insel;
   logic [31:0] ncpol;
   logic [31:0] outsel;
   logic [31:0] next_ctrl;
   logic [31:0] next_insel;
   logic [31:0] next_ncpol;
   logic [31:0] next_outsel;
   logic [31:0] next_dat;
   logic next_ack;
   logic [31:0] status;
   logic fwd_act;
   logic rev_act;
   logic src_term;
   logic bus_req;

   assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;

   always_comb begin
      status = 32'h0;
      status[`RDTL_ST_RUN] = drive_o.run;
      status[`RDTL_ST_REV] = drive_o.rev;
      status[`RDTL_ST_FWDACT] = fwd_act;
      status[`RDTL_ST_REVACT] = rev_act;
      status[`RDTL_ST_TERM +: NUM_IN] = term_s;
      status[`RDTL_ST_OUT +: NUM_OUT] = out_term_o;
   end

   always_comb begin
      next_ctrl = ctrl;
      next_insel = insel;
      next_ncpol = ncpol;
      next_outsel = outsel;
      next_dat = 32'h0;
      next_ack = bus_req;
      if (bus_req && wb_req_i.we) begin
         case (wb_req_i.adr)
            `RDTL_OFF_CTRL: begin
               next_ctrl = wb_merge(ctrl, wb_req_i.dat, wb_req_i.sel) & `RDTL_MASK_CTRL;
            end
            `RDTL_OFF_INSEL: begin
               next_insel = wb_merge(insel, wb_req_i.dat, wb_req_i.sel) & `RDTL_MASK_INSEL;
            end
            `RDTL_OFF_NCPOL: begin
               next_ncpol = wb_merge(ncpol, wb_req_i.dat, wb_req_i.sel) & `RDTL_MASK_NCPOL;
            end
            `RDTL_OFF_OUTSEL: begin
               next_outsel = wb_merge(outsel, wb_req_i.dat, wb_req_i.sel) & `RDTL_MASK_OUTSEL;
            end
            default: begin
            end
         endcase
      end else if (bus_req) begin
         case (wb_req_i.adr)
            `RDTL_OFF_CTRL: next_dat = ctrl;
            `RDTL_OFF_INSEL: next_dat = insel;
            `RDTL_OFF_NCPOL: next_dat = ncpol;
            `RDTL_OFF_OUTSEL: next_dat = outsel;
            `RDTL_OFF_STATUS: next_dat = status;
            default: next_dat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `RDTL_RST_CTRL;
         insel <= `RDTL_RST_INSEL;
         ncpol <= `RDTL_RST_NCPOL;
         outsel <= `RDTL_RST_OUTSEL;
         wb_dat_o <= 32'h0;
         wb_ack_o <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         insel <= next_insel;
         ncpol <= next_ncpol;
         outsel <= next_outsel;
         wb_dat_o <= next_dat;
         wb_ack_o <= next_ack;
      end
   end

   // ==========================================================
   // Terminal command decode
   always_comb begin
      fwd_act = 1'b0;
      rev_act = 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
         if (in_func(insel, i) == `RDTL_FN_FWD) begin
            fwd_act = fwd_act | (term_s[i] ^ ncpol[i]);
         end
         if (in_func(insel, i) == `RDTL_FN_REV) begin
            rev_act = rev_act | (term_s[i] ^ ncpol[i]);
         end
      end
   end

   assign src_term = (ctrl[`RDTL_CTRL_SRC +: 2] == `RDTL_SRC_TERMINAL);

   // ==========================================================
   // Run mode and direction
   rdtl_mode_t mode;
   rdtl_mode_t next_mode;
   rdtl_drive_t next_drive;

   always_comb begin
      next_mode = RDTL_STOP;
      if (src_term) begin
         case ({fwd_act, rev_act})
            2'b10: next_mode = RDTL_RUN_FWD;
            2'b01: next_mode = RDTL_RUN_REV;
            2'b11: next_mode = RDTL_STOP;
            default: next_mode = RDTL_STOP;
         endcase
      end else if (ctrl[`RDTL_CTRL_KPRUN]) begin
         next_mode = ctrl[`RDTL_CTRL_ROUTE] ? RDTL_RUN_REV : RDTL_RUN_FWD;
      end
      next_drive.run = (next_mode != RDTL_STOP);
      next_drive.rev = (next_mode == RDTL_RUN_REV);
   end

   // No start inhibit: a held command runs once reset ends
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= RDTL_STOP;
         drive_o <= '0;
      end else begin
         mode <= next_mode;
         drive_o <= next_drive;
      end
   end

   // ==========================================================
   // Output terminal function select
   logic [NUM_OUT-1:0] next_out;
   logic [9:0] out_flags;

   always_comb begin
      out_flags = {status_flags_i, drive_o.run};
      for (int j = 0; j < NUM_OUT; j++) begin
         next_out[j] = out_pick(outsel[j*`RDTL_OUTSEL_W +: `RDTL_OUTSEL_W], out_flags);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_term_o <= '0;
      end else begin
         out_term_o <= next_out;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [3:0] sel0;
   assign sel0 = outsel[3:0];

   sequence s_fwd_only;
      src_term && fwd_act && !rev_act;
   endsequence

   sequence s_rev_only;
      src_term && rev_act && !fwd_act;
   endsequence

   sequence s_reset_release;
      $past(rst_i) ##0 term_pin_i[0];
   endsequence

   chk_fwd_run: assert property (s_fwd_only |=> drive_o.run && !drive_o.rev)
      else $error("forward command did not run forward");

   chk_rev_run: assert property (s_rev_only |=> drive_o.run && drive_o.rev)
      else $error("reverse command did not run reverse");

   chk_idle_stop: assert property (src_term && !fwd_act && !rev_act |=> !drive_o.run)
      else $error("no command yet drive runs");

   chk_both_stop: assert property (src_term && fwd_act && rev_act |=> !drive_o.run)
      else $error("both commands did not stop");

   chk_nc_open_start: assert property (
      src_term && ncpol[0] && !term_s[0] && in_func(insel, 0) == `RDTL_FN_FWD && !rev_act
      |=> drive_o.run && !drive_o.rev)
      else $error("open normally-closed forward terminal did not start");

   chk_last_input: assert property (
      src_term && !ncpol[4] && term_s[4] && in_func(insel, 4) == `RDTL_FN_REV && !fwd_act
      |=> drive_o.rev)
      else $error("fifth selector cannot carry reverse");

   chk_pin_latency: assert property (
      src_term && in_func(insel, 2) == `RDTL_FN_FWD && !ncpol[2] && !rev_act
      && $stable(insel) && $stable(ctrl) ##0 $rose(term_s[2]) |-> ##1 drive_o.run)
      else $error("third terminal does not act like the others");

   chk_route_ignored: assert property (s_fwd_only ##0 ctrl[`RDTL_CTRL_ROUTE] |=> !drive_o.rev)
      else $error("keypad route altered terminal direction");

   chk_powerup_run: assert property (
      s_reset_release ##2 s_fwd_only |=> drive_o.run && !drive_o.rev)
      else $error("held command at power-up did not run");

   chk_out_run: assert property (sel0 == 4'h0 ##1 sel0 == 4'h0 |-> out_term_o[0] == $past(drive_o.run))
      else $error("output code 00 does not follow run");

   chk_out_bad_code: assert property (sel0 > `RDTL_OUT_MAX |=> !out_term_o[0])
      else $error("unused output code drives terminal");

   chk_src_ignore: assert property (!src_term && !ctrl[`RDTL_CTRL_KPRUN] |=> !drive_o.run)
      else $error("terminal command acted without terminal source");

   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");

   chk_ack_answer: assert property (bus_req |=> wb_ack_o)
      else $error("request not acknowledged in one cycle");

   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");

   chk_route_keypad: assert property (!src_term && ctrl[`RDTL_CTRL_KPRUN] |=>
      drive_o.run && drive_o.rev == $past(ctrl[`RDTL_CTRL_ROUTE]))
      else $error("keypad run does not follow keypad route");

   chk_mode_drive: assert property (drive_o.run == (mode != RDTL_STOP)
      && drive_o.rev == (mode == RDTL_RUN_REV))
      else $error("drive command disagrees with mode");

endmodule // rdtl_run_dir_top

// [rtl/rdtl_sync.sv]
`timescale 1ns/1ps

// ==========================================================
// Two-stage pin synchroniser
module rdtl_sync #(
   parameter int WIDTH = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end
endmodule // rdtl_sync

// [verif/rdtl_sw_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Field switches or PLC transistor outputs on the inputs
module rdtl_sw_model (
   // Clock
   input wire logic clk_i,
   // Contact commands, high closes
   input wire logic [4:0] close_i,
   // Terminal levels, high means voltage present
   output logic [4:0] term_pin_o
);
   // Contacts follow the controller scan one clock late
   always_ff @(posedge clk_i) begin
      term_pin_o <= close_i;
   end
endmodule // rdtl_sw_model

// [verif/run_direction_terminal_logic_tb.sv]
`timescale 1ns/1ps
`include "rdtl_consts.svh"

// ==========================================================
// Self-checking bench
module run_direction_terminal_logic_tb;
   import rdtl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   rdtl_wb_req_t wb_req = '0;
   logic [31:0] wb_dat;
   logic wb_ack;
   logic [4:0] close_cmd = 5'h01;
   logic [4:0] term_pin;
   logic [9:1] flags = '0;
   rdtl_drive_t drive;
   logic [1:0] out_term;
   logic [15:0] seed = 16'h2134;
   int mismatches = 0;
   int n_checks = 0;

   always #25 clk_i = ~clk_i;

   rdtl_sw_model sw (.clk_i(clk_i), .close_i(close_cmd), .term_pin_o(term_pin));

   rdtl_run_dir_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .term_pin_i(term_pin), .status_flags_i(flags), .drive_o(drive),
      .out_term_o(out_term));

   // ==========================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [3:0] exp_drive(input logic [3:0] c, input logic [29:0] s,
                                            input logic [4:0] nc, input logic [4:0] p);
      logic f;
      logic r;
      logic [4:0] a;
      a = p ^ nc;
      f = 1'b0;
      r = 1'b0;
      for (int i = 0; i < 5; i++) begin
         f |= a[i] && (s[6*i +: 6] == `RDTL_FN_FWD);
         r |= a[i] && (s[6*i +: 6] == `RDTL_FN_REV);
      end
      if (c[1:0] != `RDTL_SRC_TERMINAL) return {r, f, c[3], c[3] & c[2]};
      return {r, f, f ^ r, r & ~f};
   endfunction

   function automatic logic exp_out(input logic [3:0] code, input logic run,
                                    input logic [9:1] fl);
      if (code == 4'h0) return run;
      if (code <= `RDTL_OUT_MAX) return fl[code];
      return 1'b0;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, input logic [3:0] be = 4'hf);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: be, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      wb_req <= '0;
      q = wb_dat;
      if (wb_ack !== 1'b1) begin
         mismatches++;
         finish_test();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [3:0] c;
      logic [29:0] s;
      logic [4:0] nc;
      logic [4:0] p;
      logic [7:0] os;
      logic [9:1] fl;
      logic [3:0] e;
      logic [1:0] o;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk(drive.run, 1'b1);
      chk(drive.rev, 1'b0);
      wb(1'b0, `RDTL_OFF_CTRL, 32'h0, q);
      chk(q, `RDTL_RST_CTRL);
      wb(1'b0, `RDTL_OFF_INSEL, 32'h0, q);
      chk(q, `RDTL_RST_INSEL);
      wb(1'b0, `RDTL_OFF_OUTSEL, 32'h0, q);
      chk(q, `RDTL_RST_OUTSEL);
      wb(1'b1, `RDTL_OFF_NCPOL, 32'hffffffff, q);
      wb(1'b0, `RDTL_OFF_NCPOL, 32'h0, q);
      chk(q, `RDTL_MASK_NCPOL);
      wb(1'b1, 8'h20, 32'hffffffff, q);
      wb(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, `RDTL_OFF_INSEL, 32'h3f3f3f3f, q, 4'h4);
      wb(1'b0, `RDTL_OFF_INSEL, 32'h0, q);
      chk(q, (`RDTL_RST_INSEL & 32'hff00ffff) | 32'h003f0000);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         c = {seed[5:4], (seed[3:2] != 2'h0) ? `RDTL_SRC_TERMINAL : seed[1:0]};
         for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            s[6*k +: 6] = seed[6] ? {5'h00, seed[0]} : seed[5:0];
         end
         seed = lfsr(seed);
         nc = seed[4:0];
         os = seed[12:5];
         seed = lfsr(seed);
         p = seed[4:0];
         fl = seed[13:5];
         if (i < 2) begin
            c = 4'h5;
            s = 30'(`RDTL_RST_INSEL);
            nc = {4'h0, i[0]};
            p = i[0] ? 5'h00 : 5'h03;
         end
         wb(1'b1, `RDTL_OFF_CTRL, {28'h0, c}, q);
         wb(1'b1, `RDTL_OFF_INSEL, {2'h0, s}, q);
         wb(1'b1, `RDTL_OFF_NCPOL, {27'h0, nc}, q);
         wb(1'b1, `RDTL_OFF_OUTSEL, {24'h0, os}, q);
         close_cmd <= p;
         flags <= fl;
         repeat (7) @(posedge clk_i);
         e = exp_drive(c, s, nc, p);
         o = {exp_out(os[7:4], e[1], fl), exp_out(os[3:0], e[1], fl)};
         chk(drive.run, e[1]);
         chk(drive.rev, e[0]);
         chk(out_term[0], o[0]);
         chk(out_term[1], o[1]);
         wb(1'b0, `RDTL_OFF_STATUS, 32'h0, q);
         chk(q, {21'h0, o, p, e[3:2], e[0], e[1]});
      end
      finish_test();
   end
endmodule // run_direction_terminal_logic_tb
